// ===== rtl/tws_params.svh
// constants for the trippoint wait sequencer
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_NAX 8
`define TWS_AXW 3
`define TWS_NIN 16
`define TWS_INW 4
`define TWS_PW 32
`define TWS_CLK_NS 25
`define TWS_MS_NS 1000000
`define TWS_MS_CYCLES (`TWS_MS_NS / `TWS_CLK_NS)
`define TWS_STOP_TIMEOUT 8'h63
`define TWS_SRC_CMD 2'h0
`define TWS_SRC_ENC 2'h1
`define TWS_SRC_AUX 2'h2
`endif

// ===== rtl/tws_pkg.sv
// types shared by the trippoint wait sequencer modules
`include "tws_params.svh"
package tws_pkg;
  typedef enum logic [3:0] {
    OP_MOTION_DONE, OP_REL_DIST, OP_REPEAT_DIST, OP_ABS_POS, OP_FWD_CROSS,
    OP_REV_CROSS, OP_IN_POS, OP_SET_TIMEOUT, OP_INPUT_LEVEL, OP_SLEW,
    OP_TIMER_REF, OP_PATH_DIST, OP_MSEC_DELAY, OP_REL_MOVE
  } tws_op_e;
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} tws_state_e;
  typedef struct packed {
    tws_state_e st;
    tws_op_e op;
    logic [`TWS_AXW-1:0] ax;
    logic [`TWS_NAX-1:0] mask;
    logic seq;
    logic [1:0] src;
    logic dir;
    logic lvl;
    logic [`TWS_INW-1:0] din;
    logic [`TWS_PW-1:0] tgt;
    logic [`TWS_PW-1:0] now;
    logic [`TWS_PW-1:0] tref;
    logic [`TWS_PW-1:0] rep_base;
    logic [`TWS_PW-1:0] path_base;
    logic [`TWS_PW-1:0] tmo;
    logic [`TWS_PW-1:0] dl;
    logic tmo_on;
    logic trip;
    logic tmo_hit;
    logic err;
    logic go;
    logic [`TWS_AXW-1:0] out_ax;
  } tws_main_s;
  typedef struct packed {
    logic [`TWS_NIN-1:0] s1;
    logic [`TWS_NIN-1:0] s2;
    logic [`TWS_NIN-1:0] s3;
    logic [`TWS_NIN-1:0] lvl;
    logic [31:0] div;
    logic tick;
  } tws_tick_s;
endpackage : tws_pkg

// ===== rtl/tws_sequencer.sv
// trippoint wait sequencer: stalls a program thread until its trigger trips
`timescale 1ns/100ps
`include "tws_params.svh"
// Behaviour
// - hold the thread until motion ends on every named axis or sequence
// - relative distance trips when command position moved given distance from move start
// - repeat distance counts from the last relative or repeat trip
// - absolute position trips when the axis reaches the target
// - forward cross trips when forward motion reaches the target
// - reverse cross trips when reverse motion reaches the target
// - crossing already passed at issue trips at once
// - crossing triggers also work on encoder and auxiliary encoder positions
// - in-position needs profile finished and encoder at or past target
// - in-position timeout clears trigger, stop code 99, branches to handler
// - input level: positive waits high, negative waits low
// - slew trigger waits until the axis reaches slew speed
// - timer ref: 0 captures, +n waits, -n waits then advances reference
// - path distance counts from move start or the previous path trip
// - msec delay waits n milliseconds from issue
// - relative move on a moving axis is refused with an error
// - position trips may lag by one sample of travel
module tws_sequencer import tws_pkg::*; #(
  parameter int MS_CYCLES = `TWS_MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // command from the program sequencer
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tws_op_e cmd_op,
  input wire logic [`TWS_NAX-1:0] cmd_axes,
  input wire logic cmd_seq,
  input wire logic [1:0] cmd_src,
  input wire logic [`TWS_PW-1:0] cmd_arg,
  // thread status
  output logic busy,
  output logic trip_q,
  output logic tmo_branch_q,
  output logic stop_code_wr_q,
  output logic [7:0] stop_code_q,
  output logic [`TWS_AXW-1:0] axis_q,
  output logic cmd_err_q,
  output logic move_go_q,
  // axis profilers and encoders
  input wire logic sample_tick,
  input wire logic [`TWS_NAX-1:0][`TWS_PW-1:0] cmd_pos,
  input wire logic [`TWS_NAX-1:0][`TWS_PW-1:0] enc_pos,
  input wire logic [`TWS_NAX-1:0][`TWS_PW-1:0] aux_pos,
  input wire logic [`TWS_NAX-1:0][`TWS_PW-1:0] move_start,
  input wire logic [`TWS_NAX-1:0] moving,
  input wire logic [`TWS_NAX-1:0] profile_done,
  input wire logic [`TWS_NAX-1:0] at_slew,
  input wire logic seq_done,
  input wire logic [`TWS_PW-1:0] path_len,
  input wire logic path_start,
  // digital input pins
  input wire logic [`TWS_NIN-1:0] din_pin
);
  tws_main_s q;
  tws_main_s d;
  tws_tick_if tk ();
  logic hit;
  logic [`TWS_PW-1:0] p;
  logic [`TWS_PW-1:0] ip;
  logic [`TWS_AXW-1:0] iax;
  logic [`TWS_PW-1:0] mag;

  tws_tickgen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clock(clock),
    .nrst(nrst),
    .din_pin(din_pin),
    .tk(tk)
  );

  // a at or beyond b, wrap-safe
  function automatic logic reached(input logic [`TWS_PW-1:0] a, input logic [`TWS_PW-1:0] b);
    logic [`TWS_PW-1:0] df;
    df = a - b;
    return !df[`TWS_PW-1];
  endfunction : reached

  // lowest selected axis
  function automatic logic [`TWS_AXW-1:0] first_axis(input logic [`TWS_NAX-1:0] m);
    logic [`TWS_AXW-1:0] r;
    r = '0;
    for (int i = `TWS_NAX - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = `TWS_AXW'(i);
      end
    end
    return r;
  endfunction : first_axis

  // position of a source: command, encoder or auxiliary
  function automatic logic [`TWS_PW-1:0] src_pos(input logic [1:0] s,
      input logic [`TWS_AXW-1:0] a, input logic [`TWS_NAX-1:0][`TWS_PW-1:0] c,
      input logic [`TWS_NAX-1:0][`TWS_PW-1:0] e, input logic [`TWS_NAX-1:0][`TWS_PW-1:0] x);
    logic [`TWS_PW-1:0] r;
    r = c[a];
    if (s == `TWS_SRC_ENC) begin
      r = e[a];
    end else if (s == `TWS_SRC_AUX) begin
      r = x[a];
    end
    return r;
  endfunction : src_pos

  // issue-time helpers
  assign iax = first_axis(cmd_axes);
  assign ip = src_pos(cmd_src, iax, cmd_pos, enc_pos, aux_pos);
  assign mag = cmd_arg[`TWS_PW-1] ? (~cmd_arg + `TWS_PW'(1)) : cmd_arg;
  assign p = src_pos(q.src, q.ax, cmd_pos, enc_pos, aux_pos);

  // condition of the pending trigger
  always_comb begin
    hit = 1'b0;
    case (q.op)
      OP_MOTION_DONE: hit = ((moving & q.mask) == '0) && (!q.seq || seq_done);
      OP_REL_DIST, OP_REPEAT_DIST, OP_ABS_POS:
        hit = q.dir ? reached(q.tgt, p) : reached(p, q.tgt);
      OP_FWD_CROSS: hit = reached(p, q.tgt);
      OP_REV_CROSS: hit = reached(q.tgt, p);
      OP_IN_POS: begin
        hit = profile_done[q.ax] &&
              (q.dir ? reached(q.tgt, enc_pos[q.ax]) : reached(enc_pos[q.ax], q.tgt));
      end
      OP_INPUT_LEVEL: hit = (tk.din_lvl[q.din] == q.lvl);
      OP_SLEW: hit = at_slew[q.ax];
      OP_TIMER_REF, OP_MSEC_DELAY: hit = reached(q.now, q.dl);
      OP_PATH_DIST: hit = reached(path_len - q.path_base, q.tgt);
      default: hit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    d = q;
    d.trip = 1'b0;
    d.tmo_hit = 1'b0;
    d.err = 1'b0;
    d.go = 1'b0;
    if (tk.ms_tick) begin
      d.now = q.now + `TWS_PW'(1);
    end
    if (path_start) begin
      d.path_base = '0;
    end
    case (q.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          d.op = cmd_op;
          d.ax = iax;
          d.out_ax = iax;
          d.src = cmd_src;
          d.seq = cmd_seq;
          d.mask = (cmd_axes == '0 && !cmd_seq) ? '1 : cmd_axes;
          d.st = ST_WAIT;
          case (cmd_op)
            OP_REL_DIST: begin
              d.src = `TWS_SRC_CMD;
              d.tgt = move_start[iax] + cmd_arg;
              d.dir = cmd_arg[`TWS_PW-1];
            end
            OP_REPEAT_DIST: begin
              d.src = `TWS_SRC_CMD;
              d.tgt = q.rep_base + cmd_arg;
              d.dir = cmd_arg[`TWS_PW-1];
            end
            OP_ABS_POS: begin
              d.src = `TWS_SRC_CMD;
              d.tgt = cmd_arg;
              d.dir = !reached(cmd_arg, cmd_pos[iax]);
            end
            OP_FWD_CROSS, OP_REV_CROSS: begin
              d.tgt = cmd_arg;
              if (cmd_op == OP_FWD_CROSS ? reached(ip, cmd_arg) : reached(cmd_arg, ip)) begin
                d.st = ST_IDLE;
                d.trip = 1'b1;
              end
            end
            OP_IN_POS: begin
              d.tgt = cmd_arg;
              d.dir = !reached(cmd_arg, enc_pos[iax]);
              d.dl = q.now + q.tmo;
              d.tmo_on = (q.tmo != '0);
            end
            OP_SET_TIMEOUT: begin
              d.tmo = cmd_arg;
              d.st = ST_IDLE;
              d.trip = 1'b1;
            end
            OP_INPUT_LEVEL: begin
              d.din = `TWS_INW'(mag);
              d.lvl = !cmd_arg[`TWS_PW-1];
            end
            OP_TIMER_REF: begin
              d.tgt = cmd_arg;
              d.dl = q.tref + mag;
              if (cmd_arg == '0) begin
                d.tref = d.now;
                d.st = ST_IDLE;
                d.trip = 1'b1;
              end
            end
            OP_PATH_DIST: d.tgt = cmd_arg;
            OP_MSEC_DELAY: d.dl = q.now + cmd_arg;
            OP_REL_MOVE: begin
              d.st = ST_IDLE;
              d.err = moving[iax];
              d.go = !moving[iax];
            end
            default: d.st = ST_WAIT;
          endcase
        end
      end
      ST_WAIT: begin
        // one look per sample; travel in that sample is the lag
        if (sample_tick && hit) begin
          d.st = ST_IDLE;
          d.trip = 1'b1;
          if (q.op == OP_REL_DIST || q.op == OP_REPEAT_DIST) begin
            d.rep_base = p;
          end
          if (q.op == OP_PATH_DIST) begin
            d.path_base = path_len;
          end
          if (q.op == OP_TIMER_REF && q.tgt[`TWS_PW-1]) begin
            d.tref = q.dl;
          end
        end else if (sample_tick && q.op == OP_IN_POS && q.tmo_on && reached(q.now, q.dl)) begin
          d.st = ST_IDLE;
          d.tmo_hit = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign cmd_ready = (q.st == ST_IDLE);
  assign busy = (q.st == ST_WAIT);
  assign trip_q = q.trip;
  assign tmo_branch_q = q.tmo_hit;
  assign stop_code_wr_q = q.tmo_hit;
  assign stop_code_q = q.tmo_hit ? `TWS_STOP_TIMEOUT : 8'h00;
  assign axis_q = q.out_ax;
  assign cmd_err_q = q.err;
  assign move_go_q = q.go;

  // checks
  sequence s_issue(tws_op_e o);
    cmd_valid && cmd_ready && cmd_op == o;
  endsequence
  sequence s_wait(tws_op_e o);
    busy && q.op == o && sample_tick;
  endsequence
  sequence s_trip;
    trip_q && !busy;
  endsequence

  a_one_pending: assert property (@(posedge clock) disable iff (!nrst)
    busy |-> !cmd_ready) else $error("command taken while a trigger pends");
  a_move_refused: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_REL_MOVE) ##0 moving[first_axis(cmd_axes)] |=> cmd_err_q && !move_go_q && !busy)
    else $error("relative move on a moving axis not refused");
  a_cross_now: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_FWD_CROSS) ##0 reached(ip, cmd_arg) |=> trip_q && !busy)
    else $error("passed forward crossing did not trip at once");
  a_timeout_code: assert property (@(posedge clock) disable iff (!nrst)
    tmo_branch_q |-> stop_code_wr_q && stop_code_q == 8'h63 && !busy && !trip_q)
    else $error("timeout without stop code 99");
  a_sample_only: assert property (@(posedge clock) disable iff (!nrst)
    trip_q && $past(busy) |-> $past(sample_tick)) else $error("trip outside a sample");
  a_motion_all: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_MOTION_DONE) ##0 q.mask == '1 && moving != '0 |=> !trip_q && busy)
    else $error("motion done tripped with an axis moving");
  a_inpos_done: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_IN_POS) ##0 !profile_done[q.ax] |=> !trip_q)
    else $error("in-position tripped before profile end");
  a_slew_trip: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_SLEW) ##0 at_slew[q.ax] |=> trip_q ##1 !trip_q)
    else $error("slew trigger missed");
  a_level_trip: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_INPUT_LEVEL) ##0 tk.din_lvl[q.din] == q.lvl |=> trip_q && !busy)
    else $error("input level trigger missed");
  a_rel_move_go: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_REL_MOVE) ##0 !moving[first_axis(cmd_axes)] |=> move_go_q && !cmd_err_q && !busy)
    else $error("relative move on an idle axis not started");
  a_cross_rev_now: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_REV_CROSS) ##0 reached(cmd_arg, ip) |=> s_trip)
    else $error("passed reverse crossing did not trip at once");
  a_fwd_wait: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_FWD_CROSS) ##0 reached(p, q.tgt) |=> s_trip)
    else $error("forward crossing missed");
  a_rev_wait: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_REV_CROSS) ##0 reached(q.tgt, p) |=> s_trip)
    else $error("reverse crossing missed");
  a_timer_capture: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_TIMER_REF) ##0 cmd_arg == '0 |=> s_trip)
    else $error("timer reference capture did not answer at once");
  a_msec_hold: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_MSEC_DELAY) ##0 !reached(q.now, q.dl) |=> busy && !trip_q)
    else $error("millisecond delay ended early");
  a_path_trip: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_PATH_DIST) ##0 reached(path_len - q.path_base, q.tgt) |=> s_trip)
    else $error("path distance trigger missed");
  a_path_base: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_PATH_DIST) ##0 hit |=> q.path_base == $past(path_len))
    else $error("path base not moved to the trip point");
  a_repeat_base: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_REPEAT_DIST) ##0 hit |=> q.rep_base == $past(p))
    else $error("repeat base not moved to the trip point");
  a_seq_wait: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_MOTION_DONE) ##0 q.seq && !seq_done |=> busy && !trip_q)
    else $error("motion done left a running sequence");
  a_timeout_clear: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_IN_POS) ##0 !hit && q.tmo_on && reached(q.now, q.dl) |=> tmo_branch_q && !busy)
    else $error("in-position timeout did not branch");
  a_tmo_off: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_IN_POS) ##0 !q.tmo_on && !hit |=> busy && !tmo_branch_q)
    else $error("timeout fired while disabled");
  a_wait_quiet: assert property (@(posedge clock) disable iff (!nrst)
    busy && !sample_tick |=> !trip_q && !tmo_branch_q)
    else $error("pending trigger answered between samples");
  a_slew_hold: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_SLEW) ##0 !at_slew[q.ax] |=> busy && !trip_q)
    else $error("slew trigger tripped below slew speed");
  a_input_hold: assert property (@(posedge clock) disable iff (!nrst)
    s_wait(OP_INPUT_LEVEL) ##0 tk.din_lvl[q.din] != q.lvl |=> busy && !trip_q)
    else $error("input level trigger tripped at wrong level");
  a_axis_out: assert property (@(posedge clock) disable iff (!nrst)
    s_issue(OP_ABS_POS) |=> axis_q == $past(first_axis(cmd_axes)))
    else $error("reported axis differs from the selected axis");
endmodule : tws_sequencer

// ===== rtl/tws_tick_if.sv
// carrier for millisecond tick and filtered input levels
`timescale 1ns/100ps
`include "tws_params.svh"
interface tws_tick_if;
  logic ms_tick;
  logic [`TWS_NIN-1:0] din_lvl;
  modport src (output ms_tick, output din_lvl);
  modport dst (input ms_tick, input din_lvl);
endinterface : tws_tick_if

// ===== rtl/tws_tickgen.sv
// millisecond time base and input pin synchroniser
`timescale 1ns/100ps
`include "tws_params.svh"
module tws_tickgen import tws_pkg::*; #(
  parameter int MS_CYCLES = `TWS_MS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // raw input pins
  input wire logic [`TWS_NIN-1:0] din_pin,
  // toward the sequencer
  tws_tick_if.src tk
);
  tws_tick_s q;
  tws_tick_s d;

  // three-stage sync, divider for the ms tick
  always_comb begin
    d = q;
    d.s1 = din_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < `TWS_NIN; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i]; // change counts once stages agree
      end
    end
    d.tick = 1'b0;
    if (q.div == 32'(MS_CYCLES - 1)) begin
      d.div = 32'h0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 32'h1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tk.ms_tick = q.tick;
  assign tk.din_lvl = q.lvl;
endmodule : tws_tickgen

// ===== verification/tb_trippoint_wait_sequencer.sv
// self-checking bench for the trippoint wait sequencer
`timescale 1ns/100ps
module tb_trippoint_wait_sequencer;
  import tws_pkg::*;
  localparam int MSC = 8;
  localparam int SMP = 4;
  logic clock = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_seq = 1'b0;
  tws_op_e cmd_op = OP_MOTION_DONE;
  logic [7:0] cmd_axes = 8'h00, run = 8'h00;
  logic [1:0] cmd_src = 2'h0;
  logic [31:0] cmd_arg = 32'h0, vel = 32'h4, tgt, p0;
  logic [15:0] din_pin = 16'h0;
  logic cmd_ready, busy, trip_q, tmo_branch_q, stop_code_wr_q, cmd_err_q, move_go_q;
  logic sample_tick, seq_done, path_start, pulse;
  logic [7:0] stop_code_q, moving, profile_done, at_slew;
  logic [2:0] axis_q;
  logic [7:0][31:0] cmd_pos, enc_pos, aux_pos, move_start;
  logic [31:0] path_len;
  logic [15:0] exp_q[$];
  int mismatches = 0, total_checks = 0, cyc = 0, el;
  assign pulse = trip_q | cmd_err_q | move_go_q | tmo_branch_q;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  tws_sequencer #(.MS_CYCLES(MSC)) dut_u (.clock, .nrst, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_axes, .cmd_seq, .cmd_src, .cmd_arg, .busy, .trip_q, .tmo_branch_q, .stop_code_wr_q,
    .stop_code_q, .axis_q, .cmd_err_q, .move_go_q, .sample_tick, .cmd_pos, .enc_pos,
    .aux_pos, .move_start, .moving, .profile_done, .at_slew, .seq_done, .path_len,
    .path_start, .din_pin);
  tws_axis_model #(.SMP(SMP)) model_u (.clock, .nrst, .run, .vel, .sample_tick, .cmd_pos,
    .enc_pos, .aux_pos, .move_start, .moving, .profile_done, .at_slew, .seq_done,
    .path_len, .path_start);
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("FAIL t=%0t exp %h got %h", $time, want, got);
    end
  endtask : cmp
  task automatic cmp_res(input logic [15:0] want, input logic [15:0] got);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("FAIL t=%0t exp %h got %h", $time, want, got);
    end
  endtask : cmp_res
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask : done
  // offer one command, note its answer, hold until the take edge
  task automatic issue(input tws_op_e op, input logic [7:0] axes, input logic [1:0] src,
      input logic [31:0] arg, input logic [4:0] kind);
    logic [2:0] ax;
    ax = 3'h0;
    for (int i = 7; i >= 0; i--) if (axes[i]) ax = 3'(i);
    exp_q.push_back({kind, kind[4] ? 8'h63 : 8'h00, ax});
    cmd_op <= op;
    cmd_axes <= axes;
    cmd_src <= src;
    cmd_arg <= arg;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmp(cmd_ready, 1'b1);
    cmd_valid <= 1'b0;
  endtask : issue
  // bounded wait for any answer pulse
  task automatic wait_res(input int lim);
    el = 0;
    do begin
      @(posedge clock);
      el++;
    end while (pulse !== 1'b1 && el < lim);
    if (pulse !== 1'b1) begin
      mismatches++;
      $display("FAIL t=%0t exp %h got %h", $time, 1'b1, pulse);
    end
  endtask : wait_res
  // watcher pairs each answer pulse with the oldest note
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) begin
      cmp_res(exp_q.size() > 0 ? exp_q.pop_front() : 16'hffff, {stop_code_wr_q,
        tmo_branch_q, cmd_err_q, move_go_q, trip_q, stop_code_q, axis_q});
    end
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // main sequence; every trigger is sent as a stored program step
  initial begin
    void'($urandom(32'h8336));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    issue(OP_MSEC_DELAY, 8'h00, 2'h0, 32'd3, 5'h01);
    wait_res(100);
    cmp(el > 2 * MSC && el <= 3 * MSC + SMP + 2, 1'b1);
    done("msec");
    issue(OP_REL_MOVE, 8'h04, 2'h0, 32'd100, 5'h02);
    wait_res(4);
    vel <= 32'(2 + $urandom_range(3));
    run <= 8'h06;
    repeat (3) @(posedge clock);
    issue(OP_REL_MOVE, 8'h04, 2'h0, 32'd100, 5'h04);
    wait_res(4);
    done("relmove");
    // absolute, passed forward, encoder forward, aux reverse on one axis
    for (int k = 0; k < 4; k++) begin
      tgt = (k == 3 ? aux_pos[1] : cmd_pos[1]) + (k == 1 ? -32'd10 : k == 3 ? -32'd40 : 32'd40);
      issue(k == 0 ? OP_ABS_POS : k == 3 ? OP_REV_CROSS : OP_FWD_CROSS, 8'h02,
        2'(k == 3 ? 2 : k == 2 ? 1 : 0), tgt, 5'h01);
      wait_res(200);
      p0 = k == 3 ? tgt - aux_pos[1] : (k == 2 ? enc_pos[1] : cmd_pos[1]) - tgt;
      if (k == 1) cmp(el, 1);
      else cmp(p0 <= 2 * vel, 1'b1);
    end
    done("position");
    tgt = cmd_pos[1] - move_start[1] + 32'd30;
    issue(OP_REL_DIST, 8'h02, 2'h0, tgt, 5'h01);
    wait_res(200);
    cmp(cmd_pos[1] - move_start[1] - tgt <= 2 * vel, 1'b1);
    p0 = cmd_pos[1];
    issue(OP_REPEAT_DIST, 8'h02, 2'h0, 32'd30, 5'h01);
    wait_res(200);
    cmp(cmd_pos[1] - p0 + vel - 32'd30 <= 3 * vel, 1'b1);
    done("distance");
    run <= 8'h00;
    repeat (3) @(posedge clock);
    run <= 8'h02;
    issue(OP_SLEW, 8'h02, 2'h0, 32'h0, 5'h01);
    wait_res(100);
    cmp(el >= 2 * SMP, 1'b1);
    done("slew");
    run <= 8'h0a;
    repeat (3) @(posedge clock);
    issue(OP_MOTION_DONE, 8'h00, 2'h0, 32'h0, 5'h01);
    repeat (10) @(posedge clock);
    run <= 8'h08;
    repeat (10) @(posedge clock);
    cmp(busy, 1'b1);
    run <= 8'h00;
    wait_res(20);
    cmp(el > 1, 1'b1);
    // named axis with its sequence waits for the sequence too
    cmd_seq <= 1'b1;
    run <= 8'h02;
    repeat (3) @(posedge clock);
    issue(OP_MOTION_DONE, 8'h08, 2'h0, 32'h0, 5'h01);
    repeat (10) @(posedge clock);
    cmp(busy, 1'b1);
    run <= 8'h00;
    wait_res(20);
    // named idle axis alone trips at the first sample
    cmd_seq <= 1'b0;
    run <= 8'h02;
    repeat (3) @(posedge clock);
    issue(OP_MOTION_DONE, 8'h08, 2'h0, 32'h0, 5'h01);
    wait_res(8);
    cmp(el <= SMP + 1, 1'b1);
    run <= 8'h00;
    done("motion");
    // negative input waits low, positive waits high
    for (int s = 0; s < 2; s++) begin
      p0 = $urandom;
      din_pin <= s ? p0[15:0] & 16'hffdf : p0[15:0] | 16'h0002;
      repeat (6) @(posedge clock);
      issue(OP_INPUT_LEVEL, 8'h00, 2'h0, s ? 32'd5 : -32'd1, 5'h01);
      repeat (12) @(posedge clock);
      cmp(busy, 1'b1);
      din_pin <= s ? din_pin | 16'h0020 : din_pin & 16'hfffd;
      wait_res(14);
      cmp(el > 3, 1'b1);
    end
    done("input");
    issue(OP_TIMER_REF, 8'h00, 2'h0, 32'h0, 5'h01);
    wait_res(4);
    cmp(el, 1);
    issue(OP_TIMER_REF, 8'h00, 2'h0, -32'd2, 5'h01);
    wait_res(100);
    cmp(el > 1 && el <= 2 * MSC + SMP + 2, 1'b1);
    issue(OP_TIMER_REF, 8'h00, 2'h0, 32'd2, 5'h01);
    wait_res(100);
    cmp(el > MSC && el <= 2 * MSC + SMP + 3, 1'b1);
    done("timer");
    issue(OP_SET_TIMEOUT, 8'h00, 2'h0, 32'd2, 5'h01);
    wait_res(4);
    run <= 8'h02;
    issue(OP_IN_POS, 8'h02, 2'h0, cmd_pos[1] + 32'h1000, 5'h18);
    wait_res(100);
    cmp(el > MSC, 1'b1);
    issue(OP_SET_TIMEOUT, 8'h00, 2'h0, 32'h0, 5'h01);
    wait_res(4);
    tgt = cmd_pos[1] + vel;
    issue(OP_IN_POS, 8'h02, 2'h0, tgt, 5'h01);
    repeat (8) @(posedge clock);
    cmp(busy, 1'b1);
    run <= 8'h00;
    wait_res(12);
    cmp(enc_pos[1] - tgt < 32'h80000000, 1'b1);
    done("inpos");
    // path distance from move start, then from the previous trip
    run <= 8'h01;
    repeat (3) @(posedge clock);
    for (int j = 0; j < 2; j++) begin
      p0 = j ? path_len : 32'h0;
      issue(OP_PATH_DIST, 8'h00, 2'h0, 32'd30, 5'h01);
      wait_res(200);
      cmp(path_len - p0 - 32'd30 < vel, 1'b1);
    end
    run <= 8'h00;
    done("path");
    @(negedge clock);
    cmp(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule : tb_trippoint_wait_sequencer

// ===== verification/tws_axis_model.sv
// axis profiler, encoder and sample strobe model
`timescale 1ns/100ps
module tws_axis_model #(
  parameter int SMP = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bench controls
  input wire logic [7:0] run,
  input wire logic [31:0] vel,
  // toward the sequencer
  output logic sample_tick,
  output logic [7:0][31:0] cmd_pos,
  output logic [7:0][31:0] enc_pos,
  output logic [7:0][31:0] aux_pos,
  output logic [7:0][31:0] move_start,
  output logic [7:0] moving,
  output logic [7:0] profile_done,
  output logic [7:0] at_slew,
  output logic seq_done,
  output logic [31:0] path_len,
  output logic path_start
);
  int cnt;
  int scnt;
  logic [7:0] run_q;
  logic smp;
  assign smp = (cnt == SMP - 1);
  // strobe, profile advance, slew count and move start capture
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      scnt <= 0;
      run_q <= 8'h00;
      sample_tick <= 1'b0;
      cmd_pos <= '0;
      move_start <= '0;
    end else begin
      cnt <= smp ? 0 : cnt + 1;
      sample_tick <= smp;
      run_q <= run;
      scnt <= |(run & ~run_q) ? 0 : (smp && scnt < 3) ? scnt + 1 : scnt;
      for (int i = 0; i < 8; i++) begin
        if (run[i] && !run_q[i]) move_start[i] <= cmd_pos[i];
        if (run[i] && smp) cmd_pos[i] <= cmd_pos[i] + vel;
      end
    end
  end
  // encoder tracks command, aux input runs mirrored
  assign enc_pos = cmd_pos;
  always_comb begin
    for (int i = 0; i < 8; i++) aux_pos[i] = -cmd_pos[i];
  end
  // status levels follow the profile run
  assign moving = run_q;
  assign profile_done = ~run_q;
  assign at_slew = run_q & {8{scnt == 3}};
  assign seq_done = ~|run_q;
  assign path_len = cmd_pos[0];
  assign path_start = run[0] & ~run_q[0];
endmodule : tws_axis_model
